// [hdl/rfxcb_pkg.sv]
// Package: register map, reset values and widths of the coefficient bank
package rfxcb_pkg;
    // Register port and coefficient widths, register and coefficient counts
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COEF_W = 16;
    localparam int unsigned NUM_REGS = 10;
    localparam int unsigned NUM_COEFS = 5;
    // Page that holds this bank
    localparam logic [7:0] BANK_PAGE = 8'h01;
    // Register numbers on the page
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN1_HIGH = 7'h27;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN1_LOW = 7'h28;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN2_HIGH = 7'h29;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN2_LOW = 7'h2a;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN4_HIGH = 7'h2b;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN4_LOW = 7'h2c;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN5_HIGH = 7'h2d;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN5_LOW = 7'h2e;
    localparam logic [ADDR_W-1:0] RIGHT_DEEMPH_NUM0_HIGH = 7'h2f;
    localparam logic [ADDR_W-1:0] RIGHT_DEEMPH_NUM0_LOW = 7'h30;
    // First and last register of the bank
    localparam logic [ADDR_W-1:0] BANK_FIRST = RIGHT_FX_DEN1_HIGH;
    localparam logic [ADDR_W-1:0] BANK_LAST = RIGHT_DEEMPH_NUM0_LOW;
    // Power-on values, in register order
    localparam logic [DATA_W-1:0] RST_DEN1_HIGH = 8'h7d;
    localparam logic [DATA_W-1:0] RST_DEN1_LOW = 8'h83;
    localparam logic [DATA_W-1:0] RST_DEN2_HIGH = 8'h84;
    localparam logic [DATA_W-1:0] RST_DEN2_LOW = 8'hee;
    localparam logic [DATA_W-1:0] RST_DEN4_HIGH = 8'h7d;
    localparam logic [DATA_W-1:0] RST_DEN4_LOW = 8'h83;
    localparam logic [DATA_W-1:0] RST_DEN5_HIGH = 8'h84;
    localparam logic [DATA_W-1:0] RST_DEN5_LOW = 8'hee;
    localparam logic [DATA_W-1:0] RST_NUM0_HIGH = 8'h39;
    localparam logic [DATA_W-1:0] RST_NUM0_LOW = 8'h55;
    localparam logic [NUM_REGS*DATA_W-1:0] RST_TABLE = {
        RST_NUM0_LOW, RST_NUM0_HIGH, RST_DEN5_LOW, RST_DEN5_HIGH,
        RST_DEN4_LOW, RST_DEN4_HIGH, RST_DEN2_LOW, RST_DEN2_HIGH,
        RST_DEN1_LOW, RST_DEN1_HIGH};
    // Value read from any register outside the bank
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage

// [hdl/rfxcb_byte_reg.sv]
// One read/write coefficient byte with its power-on value
module rfxcb_byte_reg
    import rfxcb_pkg::*;
#(
    parameter logic [rfxcb_pkg::DATA_W-1:0] RESET_VALUE = 8'h00
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Write strobe and data
    input wire logic wr_en,
    input wire logic [rfxcb_pkg::DATA_W-1:0] wr_data,
    // Stored byte
    output logic [rfxcb_pkg::DATA_W-1:0] value
);
    logic [DATA_W-1:0] value_r;
    logic [DATA_W-1:0] value_nxt;

    // Load on a write, hold otherwise
    always_comb
    begin
        value_nxt = value_r;
        if (wr_en)
        begin
            value_nxt = wr_data;
        end
    end

    // Power-on value under reset; clock enable freezes the byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_r <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;
endmodule // rfxcb_byte_reg

// [hdl/rfxcb_bank.sv]
// Right-channel effects denominator and de-emphasis zero coefficient bank
module rfxcb_bank
(
    // Clock, reset and clock enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Control port register access, same clock domain
    input wire logic [7:0] page_sel,
    input wire logic [rfxcb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [rfxcb_pkg::DATA_W-1:0] reg_wdata,
    output logic [rfxcb_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_hit,
    // Coefficients to the filter datapath
    output logic signed [rfxcb_pkg::COEF_W-1:0] effects_denominator_first,
    output logic signed [rfxcb_pkg::COEF_W-1:0] effects_denominator_second,
    output logic signed [rfxcb_pkg::COEF_W-1:0] effects_denominator_fourth,
    output logic signed [rfxcb_pkg::COEF_W-1:0] effects_denominator_fifth,
    output logic signed [rfxcb_pkg::COEF_W-1:0] deemphasis_numerator_zero
);
    import rfxcb_pkg::*;

    localparam int unsigned IDX_W = 4;

    logic [DATA_W-1:0] byte_q [NUM_REGS];
    logic [NUM_REGS-1:0] wr_sel;
    logic in_bank;
    logic [IDX_W-1:0] idx;
    logic [ADDR_W-1:0] addr_off;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;
    logic [COEF_W-1:0] coef_r [NUM_COEFS];
    logic [COEF_W-1:0] coef_nxt [NUM_COEFS];

    // Address decode: the bank is one run of consecutive registers
    always_comb
    begin
        addr_off = reg_addr - BANK_FIRST;
        in_bank = (page_sel == BANK_PAGE) && (reg_addr >= BANK_FIRST)
            && (reg_addr <= BANK_LAST);
        idx = addr_off[IDX_W-1:0];
    end

    // One byte register per address, each with its own power-on value
    generate
        for (genvar i = 0; i < NUM_REGS; i++)
        begin : g_byte
            assign wr_sel[i] = reg_wr && in_bank && (idx == IDX_W'(i));
            rfxcb_byte_reg #(
                .RESET_VALUE(RST_TABLE[i*DATA_W +: DATA_W])
            ) u_byte (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .wr_en(wr_sel[i]),
                .wr_data(reg_wdata),
                .value(byte_q[i])
            );
        end
    endgenerate

    // Read mux; outside the bank reads as zero and hit stays low
    always_comb
    begin
        rdata_nxt = rdata_r;
        hit_nxt = 1'b0;
        if (reg_rd || reg_wr)
        begin
            hit_nxt = in_bank;
        end
        if (reg_rd)
        begin
            rdata_nxt = in_bank ? byte_q[idx] : UNMAPPED_READ;
        end
    end

    // Pair bytes: even index is upper, odd index is lower
    always_comb
    begin
        for (int c = 0; c < NUM_COEFS; c++)
        begin
            coef_nxt[c] = {byte_q[2*c], byte_q[2*c+1]};
        end
    end

    // Registered outputs; coefficient lags its bytes by one cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= UNMAPPED_READ;
            hit_r <= 1'b0;
            coef_r[0] <= {RST_DEN1_HIGH, RST_DEN1_LOW};
            coef_r[1] <= {RST_DEN2_HIGH, RST_DEN2_LOW};
            coef_r[2] <= {RST_DEN4_HIGH, RST_DEN4_LOW};
            coef_r[3] <= {RST_DEN5_HIGH, RST_DEN5_LOW};
            coef_r[4] <= {RST_NUM0_HIGH, RST_NUM0_LOW};
        end
        else if (clk_en)
        begin
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
            coef_r <= coef_nxt;
        end
    end

    // Signed view of each coefficient for the datapath
    assign reg_rdata = rdata_r;
    assign reg_hit = hit_r;
    assign effects_denominator_first = signed'(coef_r[0]);
    assign effects_denominator_second = signed'(coef_r[1]);
    assign effects_denominator_fourth = signed'(coef_r[2]);
    assign effects_denominator_fifth = signed'(coef_r[3]);
    assign deemphasis_numerator_zero = signed'(coef_r[4]);
endmodule // rfxcb_bank

// [test/rfxcb_bank_chk.sv]
// Assertion checker for the coefficient bank ports
module rfxcb_bank_chk
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register access
    input wire logic clk_en,
    input wire logic [7:0] page_sel,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // Coefficients
    input wire logic signed [15:0] effects_denominator_first,
    input wire logic signed [15:0] deemphasis_numerator_zero
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Decode of an accepted access on registers 39 to 48
    wire p1 = clk_en && page_sel == 8'h01;
    wire h = p1 && (reg_wr || reg_rd) && reg_addr >= 7'h27
        && reg_addr <= 7'h30;
    a_hit_decode: assert property (clk_en |=> reg_hit == $past(h))
        else $error("hit flag disagrees with decode");
    a_miss_zero: assert property (clk_en && reg_rd && !h |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_den1_write: assert property (p1 && reg_wr && reg_addr == 7'h27
        ##1 clk_en && !reg_wr |=> effects_denominator_first[15:8] ==
        $past(reg_wdata, 2)) else $error("upper byte not in 15..8");
    a_num0_low: assert property (p1 && reg_wr && reg_addr == 7'h30
        ##1 clk_en && !reg_wr |=> deemphasis_numerator_zero[7:0] ==
        $past(reg_wdata, 2)) else $error("register 48 not in 7..0");
    a_den1_reset: assert property ($rose(rst_n) |->
        effects_denominator_first == 16'h7d83) else $error("bad reset");
    a_num0_reset: assert property ($rose(rst_n) |->
        deemphasis_numerator_zero == 16'h3955) else $error("bad reset");
    a_rdata_hold: assert property (!(clk_en && reg_rd) |=>
        $stable(reg_rdata)) else $error("read data moved");
    a_frozen_state: assert property (!clk_en |=> $stable(reg_hit)
        && $stable(effects_denominator_first)) else $error("not frozen");
endmodule // rfxcb_bank_chk
bind rfxcb_bank rfxcb_bank_chk rfxcb_bank_chk_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(clk_en), .page_sel(page_sel),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .effects_denominator_first(effects_denominator_first),
    .deemphasis_numerator_zero(deemphasis_numerator_zero));

// [test/tb_rfxcb_bank.sv]
// Self-checking bench for the coefficient bank
module tb_rfxcb_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import rfxcb_pkg::*;
    logic ref_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] page_sel = 8'h01, reg_wdata = 8'h00, reg_rdata;
    logic [ADDR_W-1:0] reg_addr = 7'h00;
    logic reg_hit;
    logic signed [COEF_W-1:0] c[5];
    // Model of the ten bytes, power-on values in register order
    logic [7:0] m[10] = '{8'h7d, 8'h83, 8'h84, 8'hee, 8'h7d, 8'h83,
        8'h84, 8'hee, 8'h39, 8'h55};
    int err_count = 0, n_compared = 0;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    rfxcb_bank rfxcb_bank_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .page_sel(page_sel), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .effects_denominator_first(c[0]),
        .effects_denominator_second(c[1]),
        .effects_denominator_fourth(c[2]),
        .effects_denominator_fifth(c[3]),
        .deemphasis_numerator_zero(c[4]));
    // Inputs move 1 ns after the edge so samples never race
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp(string s, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // One compare per kind of result, all counted by cmp
    task automatic cmp_rdata(logic [7:0] e, logic [7:0] g);
        cmp("reg_rdata", 16'(e), 16'(g));
    endtask
    task automatic cmp_hit(logic e, logic g);
        cmp("reg_hit", 16'(e), 16'(g));
    endtask
    task automatic cmp_coef(logic [15:0] e, logic [15:0] g);
        cmp("coefficient", e, g);
    endtask
    // Strobes stay up between calls so back-to-back accesses never idle a cycle
    task automatic acc(bit w, logic [7:0] p, logic [6:0] a, logic [7:0] d);
        int i;
        bit h;
        i = int'(a) - 39;
        h = clk_en && p == 8'h01 && i >= 0 && i < 10;
        {page_sel, reg_addr, reg_wdata, reg_wr, reg_rd} = {p, a, d, w, !w};
        tick();
        if (w && h) m[i] = d;
        if (!w) cmp_rdata(h ? m[i] : 8'h00, reg_rdata);
        if (clk_en) cmp_hit(h, reg_hit);
    endtask
    // Idle one edge, then every coefficient against its byte pair
    task automatic coefs();
        {clk_en, reg_wr, reg_rd} = 3'b100;
        tick();
        for (int k = 0; k < 5; k++)
            cmp_coef({m[2*k], m[2*k+1]}, c[k]);
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        bit w;
        void'($urandom(32'h0707c918));
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1;
        coefs();
        for (int a = 'h25; a < 'h33; a++)
            acc(0, 8'h01, 7'(a), 8'h00);
        acc(0, 8'h02, 7'h27, 8'h00);
        acc(1, 8'h01, 7'h27, 8'h80);
        acc(1, 8'h01, 7'h28, 8'h00);
        coefs();
        cmp("sign", 16'h0001, 16'(c[0] < 0));
        // Random traffic; reads always enabled, writes sometimes frozen
        for (int n = 0; n < 300; n++)
        begin
            w = 1'($urandom_range(1));
            clk_en = !w || $urandom_range(3) != 0;
            acc(w, 8'($urandom_range(2)), 7'($urandom_range('h33, 'h24)),
                8'($urandom));
        end
        coefs();
        // Second reset in mid-run must restore every power-on value
        rst_n = 0;
        m = '{8'h7d, 8'h83, 8'h84, 8'hee, 8'h7d, 8'h83, 8'h84, 8'hee,
            8'h39, 8'h55};
        repeat (2) tick();
        rst_n = 1;
        coefs();
        for (int a = 'h27; a < 'h31; a++)
            acc(0, 8'h01, 7'(a), 8'h00);
        end_of_test();
    end
endmodule // tb_rfxcb_bank
